// ---- rtl/tmop_core.sv ----
// Object protocol core: command handling, message queue, debug port and self test.
`timescale 1ns/1ns
`include "tmop_defs.svh"
module tmop_core
(
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Mode selection.
    input wire logic hid_mode_i,
    // Command object write.
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic cmd_report_enable_bit_i,
    // Self test configuration.
    input wire logic selftest_enable_i,
    input wire logic [15:0] selftest_interval_i,
    input wire logic selftest_report_pass_i,
    input wire logic selftest_report_fail_i,
    input wire logic selftest_to_pin_i,
    input wire logic selftest_result_i,
    input wire logic pin_fault_i,
    // Message queue read by the host.
    input wire logic msg_rd_i,
    output tmop_pkg::tmop_msg_t msg_data_o,
    output logic msg_valid_o,
    output logic msg_pending_n_o,
    // HID push stream.
    input wire logic hid_ready_i,
    output logic hid_valid_o,
    // Diagnostic data object read.
    input wire logic [7:0] diag_sample_i,
    output logic [7:0] diag_data_object_o,
    // Status and pins.
    output logic config_error_flag_o,
    output logic hv_enable_o,
    output logic debug_port_en_o,
    output logic alt_func_block_o,
    output logic selftest_pin_o,
    output logic soft_reset_o,
    output logic calibrate_o
);
    import tmop_pkg::*;

    tmop_state_t state, next_state;
    logic [15:0] cnt, next_cnt;
    logic [15:0] tick, next_tick;
    logic [2:0] wptr, next_wptr, rptr, next_rptr;
    logic [3:0] fill, next_fill;
    logic nvm_rpt, next_nvm_rpt;
    logic dbg, next_dbg;
    logic hv, next_hv;
    logic stpin, next_stpin;
    logic rst_p, next_rst_p, cal_p, next_cal_p;
    logic push;
    tmop_msg_t push_msg;
    logic pop;
    logic [7:0] diag, next_diag;
    logic vld, next_vld;
    logic pend_n, next_pend_n;
    logic hvld, next_hvld;

    // Pop on host read in I2C mode, or on accepted push in HID mode.
    // Only a head that already stands on the data output may leave, so no stale word is handed over.
    assign pop = hid_mode_i ? (hvld && hid_ready_i) : (vld && msg_rd_i); // [R8]

    // Control state machine. Commands are only accepted from the command object input.
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_tick = tick;
        next_nvm_rpt = nvm_rpt;
        next_dbg = dbg;
        next_hv = hv;
        next_stpin = stpin;
        next_rst_p = 1'b0;
        next_cal_p = 1'b0;
        push = 1'b0;
        push_msg = 16'h0000;
        case (state)
            TMOP_PINTEST:
            begin
                // High voltage stays off until the pin test has run to the end. [R13]
                next_cnt = cnt + 16'h0001;
                if (cnt == `TMOP_PINTEST_CYC)
                begin
                    next_state = TMOP_IDLE;
                    next_cnt = 16'h0000;
                    next_hv = ~pin_fault_i; // [R13]
                    push = 1'b1;
                    push_msg = {`TMOP_RID_SELFTEST, pin_fault_i ? `TMOP_ST_FAIL : `TMOP_ST_PASS};
                end
            end
            TMOP_IDLE:
            begin
                if (cmd_wr_i) // [R1]
                begin
                    if (cmd_data_i == `TMOP_CMD_BACKUP)
                    begin
                        next_state = TMOP_NVM;
                        next_cnt = 16'h0000;
                        next_nvm_rpt = cmd_report_enable_bit_i;
                    end
                    else if (cmd_data_i == `TMOP_CMD_RESET)
                    begin
                        next_rst_p = 1'b1;
                    end
                    else if (cmd_data_i == `TMOP_CMD_CALIBRATE)
                    begin
                        next_cal_p = 1'b1;
                    end
                    else if (cmd_data_i == `TMOP_CMD_DEBUG_ON)
                    begin
                        next_dbg = 1'b1; // [R10]
                    end
                    else if (cmd_data_i == `TMOP_CMD_DEBUG_OFF)
                    begin
                        next_dbg = 1'b0; // [R10]
                    end
                end
                // Periodic self test only runs once enabled; a zero interval disables it. [R2] [R17]
                else if (selftest_enable_i && (selftest_interval_i != 16'h0000))
                begin
                    next_tick = tick + 16'h0001;
                    if (tick >= selftest_interval_i - 16'h0001)
                    begin
                        next_tick = 16'h0000;
                        next_state = TMOP_SELFTEST;
                    end
                end
            end
            TMOP_NVM:
            begin
                next_cnt = cnt + 16'h0001;
                if (cnt == `TMOP_NVM_BUSY_CYC)
                begin
                    next_state = TMOP_IDLE;
                    push = nvm_rpt; // [R4]
                    push_msg = {`TMOP_RID_CMD, 8'h00};
                end
            end
            default:
            begin
                // Report as configured, either as a message or on the pin. [R14] [R15]
                next_state = TMOP_IDLE;
                if (selftest_to_pin_i)
                begin
                    next_stpin = ~selftest_result_i; // [R15]
                end
                else if ((selftest_result_i && selftest_report_pass_i) ||
                         (!selftest_result_i && selftest_report_fail_i))
                begin
                    push = 1'b1; // [R14]
                    push_msg = {`TMOP_RID_SELFTEST, selftest_result_i ? `TMOP_ST_PASS : `TMOP_ST_FAIL};
                end
            end
        endcase
    end

    // Queue pointers. A full queue drops the newest message rather than overwrite unread ones.
    always_comb
    begin
        next_wptr = wptr;
        next_rptr = rptr;
        next_fill = fill;
        if (push && (fill != 4'(`TMOP_Q_DEPTH))) // [R6]
        begin
            next_wptr = wptr + 3'h1;
        end
        if (pop)
        begin
            next_rptr = rptr + 3'h1;
        end
        next_fill = fill + {3'h0, (push && (fill != 4'(`TMOP_Q_DEPTH)))} - {3'h0, pop};
        next_diag = dbg ? diag : diag_sample_i; // [R12]
        // The head word needs one edge through the registered read port, so valid trails a first write.
        next_vld = (fill > {3'h0, pop});
        next_pend_n = !(next_vld && !hid_mode_i); // [R7] [R19]
        next_hvld = next_vld && hid_mode_i; // [R8]
    end

    // Registers for all of the above.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= TMOP_PINTEST;
            cnt <= 16'h0000;
            tick <= 16'h0000;
            nvm_rpt <= 1'b0;
            dbg <= 1'b0;
            hv <= 1'b0;
            stpin <= 1'b0;
            rst_p <= 1'b0;
            cal_p <= 1'b0;
            wptr <= 3'h0;
            rptr <= 3'h0;
            fill <= 4'h0;
            diag <= 8'h00;
            vld <= 1'b0;
            pend_n <= 1'b1;
            hvld <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            tick <= next_tick;
            nvm_rpt <= next_nvm_rpt;
            dbg <= next_dbg;
            hv <= next_hv;
            stpin <= next_stpin;
            rst_p <= next_rst_p;
            cal_p <= next_cal_p;
            wptr <= next_wptr;
            rptr <= next_rptr;
            fill <= next_fill;
            diag <= next_diag;
            vld <= next_vld;
            pend_n <= next_pend_n;
            hvld <= next_hvld;
        end
    end

    // Memory read address leads by one so data is ready as the pointer moves.
    tmop_msg_mem u_mem
    (
        .core_clk_i(core_clk_i),
        .wr_en_i(push && (fill != 4'(`TMOP_Q_DEPTH))),
        .wr_addr_i(wptr),
        .wr_data_i(push_msg),
        .rd_addr_i(next_rptr),
        .rd_data_o(msg_data_o)
    );

    // Outputs straight from flip-flops, except the config error flag, which is tied low.
    assign msg_valid_o = vld;
    assign hid_valid_o = hvld;
    assign msg_pending_n_o = pend_n; // [R19]
    assign diag_data_object_o = diag;
    assign config_error_flag_o = 1'b0;
    assign hv_enable_o = hv;
    assign debug_port_en_o = dbg;
    assign alt_func_block_o = dbg; // [R11]
    assign selftest_pin_o = stpin;
    assign soft_reset_o = rst_p;
    assign calibrate_o = cal_p;

    // A push into an empty queue in plain mode, with the mode still plain one edge later.
    sequence s_first_push;
        push && (fill == 4'h0) && !hid_mode_i;
    endsequence
    sequence s_still_plain;
        !hid_mode_i;
    endsequence

    // Checks on what the host and the pins see; the pending line trails the queue by one edge.
    a_hv_after_test: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R13]
        (state == TMOP_PINTEST) |-> !hv_enable_o) else $error("hv on during pin test");
    a_debug_owns_pins: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R11]
        alt_func_block_o == debug_port_en_o) else $error("pins not owned");
    a_pend_tracks_q: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R19]
        (!hid_mode_i && fill != 4'h1) |=> (msg_pending_n_o == ($past(fill) == 4'h0)))
        else $error("pending wrong");
    a_nvm_report: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R4]
        (state == TMOP_NVM && cnt == `TMOP_NVM_BUSY_CYC && nvm_rpt && fill == 4'h0 && !pop)
        |=> (fill == 4'h1)) else $error("nvm message lost");
    a_dbg_cmd_on: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R10]
        (state == TMOP_IDLE && cmd_wr_i && cmd_data_i == `TMOP_CMD_DEBUG_ON) |=> debug_port_en_o)
        else $error("debug not on");
    a_dbg_stable: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R10]
        $rose(debug_port_en_o) |-> $past(cmd_wr_i)) else $error("debug on without command");
    a_hid_no_pend: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R8]
        hid_mode_i |=> msg_pending_n_o) else $error("pending in hid mode");
    a_push_new_msg: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R7]
        s_first_push ##1 s_still_plain |=> !msg_pending_n_o) else $error("no pending");
endmodule

// ---- rtl/tmop_defs.svh ----
// Constants for the touch object message protocol block.
// Functional notes
// R1 - Host issues reset, calibrate or backup only by writing the command object.
// R2 - Optional objects stay inactive until the host sets their enable.
// R3 - Host sets report enable before any command that writes non-volatile memory.
// R4 - Finished NVM write with reporting on queues a message and asserts pending. In HID mode the code queues the message but leaves pending high.
// R5 - Host checks the pending message's report id before driving reset.
// R6 - All status is held as messages in the message queue object.
// R7 - In plain I2C mode pending asserts whenever a new message appears.
// R8 - In HID mode queued messages are pushed to the host automatically.
// R9 - Host waits for notification and does not poll.
// R10 - Debug port is off after reset, enabled only by the command object.
// R11 - While debug port is on, the device owns those pins, alternates blocked.
// R12 - Diagnostic debug data is readable through the diagnostic object.
// R13 - Power-up pin fault test completes before the high voltage supply enables.
// R14 - Enabled self test repeats at a set interval, reporting pass and/or fail.
// R15 - Self test results go to messages or to a configured output pin.
// R16 - Host limits configuration NVM writes to 10,000 over the lifetime.
// R17 - Zero fields are safe and disable; settings persist only after backup.
// R18 - Host derives report id ranges from the object table.
// R19 - Pending line is active low, released when all messages are read.
`ifndef TMOP_DEFS_SVH
`define TMOP_DEFS_SVH
`define TMOP_CMD_RESET 8'h01
`define TMOP_CMD_BACKUP 8'h02
`define TMOP_CMD_CALIBRATE 8'h03
`define TMOP_CMD_DEBUG_ON 8'h04
`define TMOP_CMD_DEBUG_OFF 8'h05
`define TMOP_RID_CMD 8'h01
`define TMOP_RID_SELFTEST 8'h02
`define TMOP_ST_PASS 8'hfe
`define TMOP_ST_FAIL 8'h11
`define TMOP_NVM_BUSY_CYC 16'h0040
`define TMOP_PINTEST_CYC 16'h0020
`define TMOP_Q_DEPTH 8
`define TMOP_Q_AW 3
`define TMOP_MSG_W 16
`define TMOP_TICK_CYC 16'h0064
`endif

// ---- rtl/tmop_msg_mem.sv ----
// Small message memory with registered read data.
`timescale 1ns/1ns
module tmop_msg_mem
(
    // Clock.
    input wire logic core_clk_i,
    // Write side.
    input wire logic wr_en_i,
    input wire logic [2:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    // Read side.
    input wire logic [2:0] rd_addr_i,
    output logic [15:0] rd_data_o
);
    logic [15:0] mem [0:7];

    // Storage and registered read; no reset so it maps to memory.
    always_ff @(posedge core_clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// ---- rtl/tmop_pkg.sv ----
// Types for the touch object message protocol block.
package tmop_pkg;
    typedef enum logic [2:0] {TMOP_PINTEST, TMOP_IDLE, TMOP_NVM, TMOP_SELFTEST} tmop_state_t;
    typedef logic [15:0] tmop_msg_t;
endpackage

// ---- tb/tb.sv ----
// Self-checking bench for the object protocol core.
`timescale 1ns/1ns
`include "tmop_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
    import tmop_pkg::*;
    logic core_clk = 1'b0;
    logic resetn;
    logic hid_mode = 0, cmd_wr = 0, rpt = 0, st_en = 0, st_pass = 0, st_fail = 0, st_pin = 0, st_res = 1;
    logic pfault = 0, slow = 0, msg_rd, hid_rdy, msg_valid, pend_n, hid_valid, cfg_err, hv, dbg, alt, st_pin_o;
    logic srst, cal;
    logic [7:0] cmd_data = 8'h00, diag = 8'h00, diag_o, old;
    logic [15:0] st_int = 16'h0000;
    logic [31:0] seed = 32'h5f44;
    tmop_msg_t msg_data;
    tmop_msg_t exp_q[$];
    int err_count = 0, n_checks = 0, k;
    integer n_srst = 0, n_cal = 0;
    always #5 core_clk = ~core_clk;
    // Pulse counters; an unknown pulse turns the count unknown and fails its check.
    always @(posedge core_clk)
    begin
        n_srst <= n_srst + srst;
        n_cal <= n_cal + cal;
    end
    tmop_core tmop_core_i (.core_clk_i(core_clk), .resetn_i(resetn), .hid_mode_i(hid_mode), .cmd_wr_i(cmd_wr),
        .cmd_data_i(cmd_data), .cmd_report_enable_bit_i(rpt), .selftest_enable_i(st_en),
        .selftest_interval_i(st_int), .selftest_report_pass_i(st_pass), .selftest_report_fail_i(st_fail),
        .selftest_to_pin_i(st_pin), .selftest_result_i(st_res), .pin_fault_i(pfault), .msg_rd_i(msg_rd),
        .msg_data_o(msg_data), .msg_valid_o(msg_valid), .msg_pending_n_o(pend_n), .hid_ready_i(hid_rdy),
        .hid_valid_o(hid_valid), .diag_sample_i(diag), .diag_data_object_o(diag_o), .config_error_flag_o(cfg_err),
        .hv_enable_o(hv), .debug_port_en_o(dbg), .alt_func_block_o(alt), .selftest_pin_o(st_pin_o),
        .soft_reset_o(srst), .calibrate_o(cal));
    tmop_host_model tmop_host_model_i (.core_clk_i(core_clk), .resetn_i(resetn), .hid_mode_i(hid_mode),
        .slow_i(slow), .msg_pending_n_i(pend_n), .msg_data_i(msg_data), .hid_valid_i(hid_valid),
        .msg_rd_o(msg_rd), .hid_ready_o(hid_rdy));
    // Next value of the stimulus shift register.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] c, input logic r);
        cmd_data = c;
        rpt = r;
        cmd_wr = 1'b1;
        tick(1);
        cmd_wr = 1'b0;
    endtask
    task automatic do_reset(input logic f);
        resetn = 1'b0;
        pfault = f;
        tick(2);
        `CHK({pend_n, hv, dbg, alt, cfg_err}, 5'h10)
        tmop_host_model_i.got.delete();
        resetn = 1'b1;
        tick(3);
        `CHK(hv, 1'b0)
        tick(40);
        `CHK(hv, !f)
        exp_q.push_back({`TMOP_RID_SELFTEST, f ? `TMOP_ST_FAIL : `TMOP_ST_PASS});
    endtask
    // Compares what the host collected with the expected messages, in order.
    // Each side is popped once into a local, so a mismatch report cannot pop a second time.
    task automatic drain;
        tmop_msg_t g;
        tmop_msg_t e;
        tick(30);
        `CHK(tmop_host_model_i.got.size(), exp_q.size())
        while (exp_q.size() > 0 && tmop_host_model_i.got.size() > 0)
        begin
            g = tmop_host_model_i.got.pop_front();
            e = exp_q.pop_front();
            `CHK(g, e)
        end
        exp_q.delete();
        tmop_host_model_i.got.delete();
    endtask
    task automatic st_run(input logic p, input logic f, input logic r, input logic [7:0] s);
        st_pass = p;
        st_fail = f;
        st_res = r;
        st_en = 1'b1;
        tick(300);
        tmop_host_model_i.got.delete();
        tick(500);
        `CHK(tmop_host_model_i.got.size() > 1, s != 8'h00)
        foreach (tmop_host_model_i.got[i])
            `CHK(tmop_host_model_i.got[i], {`TMOP_RID_SELFTEST, s})
        $display("end selftest phase %h", s);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog; the full sequence needs well under a third of this span.
    initial
    begin
        #200000;
        err_count++;
        stop_test;
    end
    initial
    begin
        do_reset(1'b0);
        drain;
        seed = lfsr(seed);
        diag = seed[7:0];
        tick(3);
        `CHK(diag_o, diag)
        cmd(`TMOP_CMD_DEBUG_ON, 1'b0);
        tick(2);
        `CHK({dbg, alt}, 2'h3)
        old = diag;
        diag = ~diag;
        tick(3);
        `CHK(diag_o, old)
        cmd(`TMOP_CMD_DEBUG_OFF, 1'b0);
        tick(2);
        `CHK({dbg, alt}, 2'h0)
        k = n_cal;
        cmd(`TMOP_CMD_CALIBRATE, 1'b0);
        tick(5);
        `CHK(n_cal - k, 1)
        cmd(`TMOP_CMD_BACKUP, 1'b0); // Three backups in the run, far inside the write budget.
        tick(80);
        drain;
        cmd(`TMOP_CMD_BACKUP, 1'b1);
        for (k = 0; k < 90 && pend_n !== 1'b0; k++)
            tick(1);
        `CHK(pend_n, 1'b0)
        `CHK(msg_valid, 1'b1)
        `CHK(msg_data[15:8], `TMOP_RID_CMD)
        exp_q.push_back({`TMOP_RID_CMD, 8'h00});
        drain;
        $display("end commands");
        hid_mode = 1'b1;
        slow = 1'b1;
        cmd(`TMOP_CMD_BACKUP, 1'b1);
        k = 0;
        repeat (90)
        begin
            tick(1);
            k += (pend_n !== 1'b1);
        end
        `CHK(k, 0)
        exp_q.push_back({`TMOP_RID_CMD, 8'h00});
        drain;
        hid_mode = 1'b0;
        $display("end push mode");
        st_int = 16'h0014 + seed[11:8];
        st_run(1'b1, 1'b0, 1'b1, `TMOP_ST_PASS);
        st_run(1'b1, 1'b0, 1'b0, 8'h00);
        st_run(1'b0, 1'b1, 1'b0, `TMOP_ST_FAIL);
        st_pin = 1'b1;
        tick(400);
        `CHK(st_pin_o, 1'b1)
        st_res = 1'b1;
        tick(400);
        `CHK(st_pin_o, 1'b0)
        st_en = 1'b0;
        st_pin = 1'b0;
        tick(300);
        tmop_host_model_i.got.delete();
        tick(500);
        `CHK(tmop_host_model_i.got.size(), 0)
        k = n_srst;
        cmd(`TMOP_CMD_RESET, 1'b0);
        tick(5);
        `CHK(n_srst - k, 1)
        do_reset(1'b1);
        drain;
        $display("end pin fault");
        stop_test;
    end
endmodule

// ---- tb/tmop_host_model.sv ----
// Host model that drains the message queue only when notified.
`timescale 1ns/1ns
module tmop_host_model
(
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Mode and pacing.
    input wire logic hid_mode_i,
    input wire logic slow_i,
    // Message side of the block.
    input wire logic msg_pending_n_i,
    input wire tmop_pkg::tmop_msg_t msg_data_i,
    input wire logic hid_valid_i,
    output logic msg_rd_o,
    output logic hid_ready_o
);
    import tmop_pkg::*;
    tmop_msg_t got[$];
    int gap;
    logic stall;
    // Acts just after each edge; the slow pace leaves gaps and stalls the push stream, as a busy host would.
    initial
    begin
        msg_rd_o = 1'b0;
        hid_ready_o = 1'b0;
        gap = 0;
        stall = 1'b0;
        forever
        begin
            @(posedge core_clk_i);
            if (hid_valid_i && hid_ready_o)
                got.push_back(msg_data_i);
            #1;
            stall = slow_i && !stall;
            hid_ready_o = hid_mode_i && !stall;
            if (msg_rd_o)
            begin
                msg_rd_o = 1'b0;
                gap = slow_i ? 3 : 1;
            end
            else if (gap > 0)
                gap--;
            else if (resetn_i && !hid_mode_i && msg_pending_n_i == 1'b0)
            begin
                got.push_back(msg_data_i);
                msg_rd_o = 1'b1;
            end
        end
    end
endmodule
